// *** bench/bridge_cfg_regs_props.sv ***
/*
  Checker on the ports of the bridge configuration bank.
  Assumes a bind from the bench top, one clock, async active-low reset.
*/
`timescale 1ns/100ps
module bridge_cfg_regs_props
(
  // Clock and reset
  input wire logic                        clock,
  input wire logic                        nrst,
  // Watched ports
  input wire bridge_cfg_pkg::cfg_req_t    cfgReq,
  input wire logic [31:0]                 cfgRdata,
  input wire logic                        cfgRdValid,
  input wire bridge_cfg_pkg::window_low_t windowLow,
  input wire bridge_cfg_pkg::route_req_t  routeReq,
  input wire logic                        routeDone,
  input wire logic                        routeToPort,
  input wire logic [15:0]                 bridgeControl,
  input wire logic                        hotResetActive,
  input wire logic                        hotResetStart,
  input wire logic [7:0]                  interruptLine
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Config reads
  chk_read_answer: assert property (cfgReq.rd |=> cfgRdValid)
    else $error("read answer missing");
  chk_cap_pointer: assert property (
    cfgReq.rd && cfgReq.addr[7:2] == 6'h0d |=> cfgRdata == 32'h0000_0088)
    else $error("capability pointer wrong");
  chk_pin_line: assert property (
    cfgReq.rd && cfgReq.addr[7:2] == 6'h0f
    |=> cfgRdata[15:0] == {8'h01, $past(interruptLine)})
    else $error("pin or line byte wrong");
  chk_reserved_zero: assert property (
    cfgReq.rd && cfgReq.addr[7:2] == 6'h0f |=> cfgRdata[31:28] == 4'h0)
    else $error("reserved control bits set");
  // Control word
  chk_timer_zero: assert property (bridgeControl[11:8] == 4'h0)
    else $error("discard timer bits set");
  chk_hot_level: assert property (
    cfgReq.wr && cfgReq.addr[7:2] == 6'h0f && cfgReq.byteEn[2]
    |=> hotResetActive == $past(cfgReq.wdata[22]) && bridgeControl[6] == hotResetActive)
    else $error("hot reset level wrong");
  chk_hot_pulse: assert property (
    hotResetStart |-> hotResetActive && !$past(hotResetActive))
    else $error("hot reset pulse wrong");
  // Routing
  chk_route_nonpf: assert property (
    routeReq.valid && !routeReq.prefetch |=> routeDone && !routeToPort)
    else $error("non-prefetch access forwarded");
  chk_route_below: assert property (
    routeReq.valid && routeReq.addr[39:20] < {windowLow.baseHigh, windowLow.baseLow}
    |=> routeDone && !routeToPort)
    else $error("access below base forwarded");
  chk_route_idle: assert property (!routeReq.valid |=> !routeDone && !routeToPort)
    else $error("spurious routing answer");
  // Main scenarios
  cov_hot: cover property (hotResetStart);
  cov_hit: cover property (routeDone && routeToPort);
  cov_read: cover property (cfgRdValid && cfgRdata != 32'h0000_0000);
endmodule

// *** bench/bridge_cfg_regs_tb.sv ***
/*
  Testbench of the bridge configuration bank: register table, routing, resets.
  Assumes the bank, its package and the port model are compiled first.
*/
`timescale 1ns/100ps
module bridge_cfg_regs_tb;
  typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] wd, ex;} row_t;
  logic clock, nrst, cfgRdValid, routeDone, routeToPort, hotResetActive, hotResetStart;
  logic [31:0] cfgRdata;
  logic [15:0] bridgeControl;
  logic [7:0]  interruptLine;
  bridge_cfg_pkg::cfg_req_t    cfgReq;
  bridge_cfg_pkg::route_req_t  routeReq;
  bridge_cfg_pkg::window_low_t windowLow;
  int nErrors, comparisons, hotResets, forwarded;
  row_t rows [6] = '{'{8'h2c, 4'hf, 32'h1234_5678, 32'h1234_5678},
    '{8'h2c, 4'h1, 32'hffff_ff02, 32'h1234_5602}, '{8'h34, 4'hf, '1, 32'h0000_0088},
    '{8'h3c, 4'hf, 32'hffff_ffa5, 32'h005f_01a5}, '{8'h3c, 4'h5, 32'h0000_0011, 32'h0000_0111},
    '{8'h40, 4'hf, '1, 32'h0000_0000}};
  logic [41:0] routes [5] = '{{2'b10, 40'h01_0fff_ffff}, {2'b11, 40'h01_1000_0000},
    {2'b11, 40'h02_1fff_ffff}, {2'b10, 40'h02_2000_0000}, {2'b00, 40'h01_8000_0000}};
  bridge_cfg_regs u_dut (.clock(clock), .nrst(nrst), .cfgReq(cfgReq), .cfgRdata(cfgRdata),
    .cfgRdValid(cfgRdValid), .windowLow(windowLow), .routeReq(routeReq),
    .routeDone(routeDone), .routeToPort(routeToPort), .bridgeControl(bridgeControl),
    .hotResetActive(hotResetActive), .hotResetStart(hotResetStart),
    .interruptLine(interruptLine));
  port_side_model u_port (.clock(clock), .nrst(nrst), .hotResetStart(hotResetStart),
    .routeDone(routeDone), .routeToPort(routeToPort), .hotResets(hotResets),
    .forwarded(forwarded));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus cycles and verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    cfgReq = '{rd: 1'b0, wr: 1'b1, addr: a, byteEn: be, wdata: d};
    @(negedge clock);
  endtask
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
    cfgReq = '{rd: 1'b1, wr: 1'b0, addr: a, byteEn: 4'h0, wdata: 32'h0000_0000};
    @(negedge clock);
    chk("cfgRdValid", 32'h0000_0001, {31'h0, cfgRdValid});
    chk("cfgRdata", exp, cfgRdata);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", comparisons, nErrors);
    if (nErrors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Watchdog
  initial
  begin
    #20000;
    nErrors++;
    complete_run;
  end
  // Main sequence
  initial
  begin
    nErrors = 0;
    comparisons = 0;
    nrst = 1'b0;
    cfgReq = '0;
    routeReq = '0;
    windowLow = '{baseLow: 12'h100, baseHigh: 8'h01, limitLow: 12'h1ff};
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    foreach (rows[i])
    begin
      cfg_write(rows[i].a, rows[i].be, rows[i].wd);
      cfg_read(rows[i].a, rows[i].ex);
    end
    chk("interruptLine", 32'h0000_0011, {24'h0, interruptLine});
    // Hot reset on a single-lane control write
    cfg_write(8'h3c, 4'h4, 32'h0040_0000);
    cfgReq = '0;
    chk("hotResetStart", 32'h0000_0001, {31'h0, hotResetStart});
    chk("hotResetActive", 32'h0000_0001, {31'h0, hotResetActive});
    chk("bridgeControl", 32'h0000_0040, {16'h0, bridgeControl});
    @(negedge clock);
    chk("hotResets", 32'h0000_0002, hotResets);
    // Limit upper programmed first; bits above A[39:32] must not matter
    cfg_write(8'h2c, 4'hf, 32'hffff_ff02);
    cfgReq = '0;
    foreach (routes[i])
    begin
      routeReq = '{valid: 1'b1, prefetch: routes[i][41], addr: routes[i][39:0]};
      @(negedge clock);
      chk("routeDone", 32'h0000_0001, {31'h0, routeDone});
      chk("routeToPort", {31'h0, routes[i][40]}, {31'h0, routeToPort});
    end
    routeReq = '0;
    @(negedge clock);
    chk("forwarded", 32'h0000_0002, forwarded);
    // Second reset in mid-run restores the reset values
    nrst = 1'b0;
    @(negedge clock) nrst = 1'b1;
    cfg_read(8'h2c, 32'h0000_0000);
    cfg_read(8'h3c, 32'h0000_0100);
    chk("bridgeControl", 32'h0000_0000, {16'h0, bridgeControl});
    complete_run;
  end
endmodule
bind bridge_cfg_regs bridge_cfg_regs_props u_props (.clock(clock), .nrst(nrst),
  .cfgReq(cfgReq), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid), .windowLow(windowLow),
  .routeReq(routeReq), .routeDone(routeDone), .routeToPort(routeToPort),
  .bridgeControl(bridgeControl), .hotResetActive(hotResetActive),
  .hotResetStart(hotResetStart), .interruptLine(interruptLine));

// *** bench/port_side_model.sv ***
/*
  Downstream port model: counts hot resets and forwarded accesses.
  Assumes the bank's registered one-cycle pulses.
*/
`timescale 1ns/100ps
module port_side_model
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // From the bank
  input  wire logic hotResetStart,
  input  wire logic routeDone,
  input  wire logic routeToPort,
  // Counts
  output int        hotResets,
  output int        forwarded
);
  // Hot reset entry and accepted accesses
  always @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      hotResets <= 0;
      forwarded <= 0;
    end
    else
    begin
      hotResets <= hotResets + int'(hotResetStart);
      forwarded <= forwarded + int'(routeDone && routeToPort);
    end
endmodule

// *** core/bridge_cfg_pkg.sv ***
/*
  Package for the bridge configuration register bank: register offsets,
  field positions, reset values and the carrier structs that travel between
  the configuration port, the routing port and the bank.
  Assumes a 256-byte configuration space that is reached one dword at a time.
*/
package bridge_cfg_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned CFG_ADDR_W   = 8;
  localparam int unsigned HOST_ADDR_W  = 40;
  localparam int unsigned WIN_LOW_W    = 12;
  localparam int unsigned WIN_HIGH_W   = 8;
  localparam int unsigned BLOCK_BITS   = 20;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets in configuration space
  localparam logic [7:0] PREFETCH_LIMIT_HIGH_OFS = 8'h2c;
  localparam logic [7:0] CAP_LIST_PTR_OFS        = 8'h34;
  localparam logic [7:0] INT_ROUTING_LINE_OFS    = 8'h3c;
  localparam logic [7:0] INT_PIN_SELECT_OFS      = 8'h3d;
  localparam logic [7:0] BRIDGE_CONTROL_OFS      = 8'h3e;

  //////////////////////////////////////////////////////////////////////////////
  // Reset and fixed values
  localparam logic [31:0] PREFETCH_LIMIT_HIGH_RST = 32'h0000_0000;
  localparam logic [7:0]  CAP_LIST_PTR_VAL        = 8'h88;
  localparam logic [7:0]  INT_ROUTING_LINE_RST    = 8'h00;
  localparam logic [7:0]  INT_PIN_SELECT_VAL      = 8'h01;
  localparam logic [15:0] BRIDGE_CONTROL_RST      = 16'h0000;

  // Window block fill values for the low twenty address bits
  localparam logic [19:0] LIMIT_LOW_FILL = 20'hf_ffff;
  localparam logic [19:0] BASE_LOW_FILL  = 20'h0_0000;

  //////////////////////////////////////////////////////////////////////////////
  // Bridge control field positions
  localparam int unsigned BCTRL_PARITY_RESP_BIT  = 0;
  localparam int unsigned BCTRL_SERR_EN_BIT      = 1;
  localparam int unsigned BCTRL_ISA_EN_BIT       = 2;
  localparam int unsigned BCTRL_VGA_EN_BIT       = 3;
  localparam int unsigned BCTRL_VGA16_BIT        = 4;
  localparam int unsigned BCTRL_HOT_RESET_BIT    = 6;
  // Writable bits of the low control byte; bits 5 and 7 stay zero
  localparam logic [7:0]  BCTRL_LOW_RW_MASK      = 8'h5f;
  // Whole high byte: discard timer fields and reserved bits, all zero
  localparam logic [7:0]  BCTRL_HIGH_VAL         = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [CFG_ADDR_W-1:0] addr;
    logic [3:0]            byteEn;
    logic [31:0]           wdata;
  } cfg_req_t;

  typedef struct packed {
    logic                   valid;
    logic                   prefetch;
    logic [HOST_ADDR_W-1:0] addr;
  } route_req_t;

  typedef struct packed {
    logic [WIN_LOW_W-1:0]  baseLow;
    logic [WIN_HIGH_W-1:0] baseHigh;
    logic [WIN_LOW_W-1:0]  limitLow;
  } window_low_t;

endpackage

// *** core/bridge_cfg_regs.sv ***
/*
  Configuration register bank for the upper part of a virtual host to
  PCI Express bridge header: prefetchable limit upper dword, capabilities
  pointer, interrupt line and pin, and the bridge control word. Also routes
  processor prefetchable accesses against the programmed window.
  Assumes the lower base and limit fields come from the neighbouring bank,
  and that configuration requests are single-cycle strobes on the clock.
*/
// How it works
// - Upper limit dword, read/write, resets zero
// - Forward prefetchable access only inside base..limit
// - Limit low twenty bits compare as ones
// - Limit bits from lower register and upper byte
// - Capabilities pointer reads fixed 88h
// - Interrupt line byte stored, never used
// - Interrupt pin reads fixed 01h
// - Control bits 11 to 8 hardwired zero
// - Secondary bus reset bit requests hot reset
`timescale 1ns/100ps

module bridge_cfg_regs
(
  // Clock and reset
  input  wire logic                                       clock,
  input  wire logic                                       nrst,
  // Configuration space port
  input  wire bridge_cfg_pkg::cfg_req_t                   cfgReq,
  output logic [31:0]                                     cfgRdata,
  output logic                                            cfgRdValid,
  // Window fields held by the neighbouring bank
  input  wire bridge_cfg_pkg::window_low_t                windowLow,
  // Processor access routing
  input  wire bridge_cfg_pkg::route_req_t                 routeReq,
  output logic                                            routeDone,
  output logic                                            routeToPort,
  // Bridge control toward the port and neighbours
  output logic [15:0]                                     bridgeControl,
  output logic                                            hotResetActive,
  output logic                                            hotResetStart,
  // Interrupt line value for software only
  output logic [7:0]                                      interruptLine
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [31:0] limitHigh;
    logic [7:0]  intLine;
    logic [7:0]  bctrlLow;
    logic [31:0] rdata;
    logic        rdValid;
    logic        routeDone;
    logic        routeHit;
    logic        hotStart;
  } state_t;

  state_t state_q;
  state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [bridge_cfg_pkg::CFG_ADDR_W-1:0] dwordAddr;
  logic                                  selLimitHigh;
  logic                                  selCapPtr;
  logic                                  selIntDword;

  // Config cycles are dword based; byte lanes pick within the dword
  assign dwordAddr    = {cfgReq.addr[bridge_cfg_pkg::CFG_ADDR_W-1:2], 2'b00};
  assign selLimitHigh = (dwordAddr == bridge_cfg_pkg::PREFETCH_LIMIT_HIGH_OFS);
  assign selCapPtr    = (dwordAddr == bridge_cfg_pkg::CAP_LIST_PTR_OFS);
  assign selIntDword  = (dwordAddr == bridge_cfg_pkg::INT_ROUTING_LINE_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Read word assembly
  logic [15:0] bctrlWord;
  logic [31:0] intDword;
  logic [31:0] capDword;
  logic [31:0] readWord;

  // High byte is discard timers and reserved bits, all fixed zero
  assign bctrlWord = {bridge_cfg_pkg::BCTRL_HIGH_VAL, state_q.bctrlLow};

  // Line, pin and control share one dword in their printed byte lanes
  assign intDword = {bctrlWord,
                     bridge_cfg_pkg::INT_PIN_SELECT_VAL,
                     state_q.intLine};

  // Pointer occupies lane 0 of its dword; upper lanes reserved
  assign capDword = {24'h00_0000, bridge_cfg_pkg::CAP_LIST_PTR_VAL};

  // Unmapped offsets read as zero
  always_comb
  begin
    readWord = 32'h0000_0000;
    if (selLimitHigh)
    begin
      readWord = state_q.limitHigh;
    end
    else if (selCapPtr)
    begin
      readWord = capDword;
    end
    else if (selIntDword)
    begin
      readWord = intDword;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane write merge
  logic [31:0] limitHighWr;
  logic [7:0]  bctrlLowWr;

  // Each enabled lane replaces its byte of the upper limit
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : gLimitLane
      assign limitHighWr[lane*8 +: 8] = cfgReq.byteEn[lane]
                                        ? cfgReq.wdata[lane*8 +: 8]
                                        : state_q.limitHigh[lane*8 +: 8];
    end
  endgenerate

  // Fixed-zero bits of the low control byte ignore writes
  assign bctrlLowWr = cfgReq.wdata[23:16] & bridge_cfg_pkg::BCTRL_LOW_RW_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Window comparison
  logic inWindow;

  // Limit upper byte is the low byte of the upper dword
  prefetch_window_match uWindow
  (
    .addr      (routeReq.addr),
    .baseLow   (windowLow.baseLow),
    .baseHigh  (windowLow.baseHigh),
    .limitLow  (windowLow.limitLow),
    .limitHigh (state_q.limitHigh[bridge_cfg_pkg::WIN_HIGH_W-1:0]),
    .inWindow  (inWindow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic hotNext;

  always_comb
  begin
    state_d = state_q;
    hotNext = state_q.bctrlLow[bridge_cfg_pkg::BCTRL_HOT_RESET_BIT];

    // Configuration writes
    if (cfgReq.wr)
    begin
      if (selLimitHigh)
      begin
        state_d.limitHigh = limitHighWr;
      end
      if (selIntDword && cfgReq.byteEn[0])
      begin
        state_d.intLine = cfgReq.wdata[7:0];
      end
      // Lane 1 is the read-only pin byte, lane 3 is all fixed zero
      if (selIntDword && cfgReq.byteEn[2])
      begin
        state_d.bctrlLow = bctrlLowWr;
        hotNext = bctrlLowWr[bridge_cfg_pkg::BCTRL_HOT_RESET_BIT];
      end
    end

    // Read answer one cycle after the strobe
    state_d.rdValid = cfgReq.rd;
    if (cfgReq.rd)
    begin
      state_d.rdata = readWord;
    end

    // Routing decision one cycle after the request
    state_d.routeDone = routeReq.valid;
    state_d.routeHit  = routeReq.valid && routeReq.prefetch && inWindow;

    // Rising edge of the secondary bus reset bit starts a hot reset
    state_d.hotStart = hotNext
                       && !state_q.bctrlLow[bridge_cfg_pkg::BCTRL_HOT_RESET_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q.limitHigh <= bridge_cfg_pkg::PREFETCH_LIMIT_HIGH_RST;
      state_q.intLine   <= bridge_cfg_pkg::INT_ROUTING_LINE_RST;
      state_q.bctrlLow  <= bridge_cfg_pkg::BRIDGE_CONTROL_RST[7:0];
      state_q.rdata     <= 32'h0000_0000;
      state_q.rdValid   <= 1'b0;
      state_q.routeDone <= 1'b0;
      state_q.routeHit  <= 1'b0;
      state_q.hotStart  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cfgRdata       = state_q.rdata;
  assign cfgRdValid     = state_q.rdValid;
  assign routeDone      = state_q.routeDone;
  assign routeToPort    = state_q.routeHit;
  assign bridgeControl  = bctrlWord;
  // Port stays in hot reset while the bit is held set
  assign hotResetActive = state_q.bctrlLow[bridge_cfg_pkg::BCTRL_HOT_RESET_BIT];
  assign hotResetStart  = state_q.hotStart;
  // Stored for software; nothing inside depends on it
  assign interruptLine  = state_q.intLine;

endmodule

// *** core/prefetch_window_match.sv ***
/*
  Window comparator for processor prefetchable memory routing.
  Assumes the base and limit fields are stable while an access is presented;
  the result is combinational and is registered by the caller.
*/
`timescale 1ns/100ps

module prefetch_window_match
(
  // Access address
  input  wire logic [bridge_cfg_pkg::HOST_ADDR_W-1:0] addr,
  // Window fields
  input  wire logic [bridge_cfg_pkg::WIN_LOW_W-1:0]   baseLow,
  input  wire logic [bridge_cfg_pkg::WIN_HIGH_W-1:0]  baseHigh,
  input  wire logic [bridge_cfg_pkg::WIN_LOW_W-1:0]   limitLow,
  input  wire logic [bridge_cfg_pkg::WIN_HIGH_W-1:0]  limitHigh,
  // Result
  output logic                                        inWindow
);

  logic [bridge_cfg_pkg::HOST_ADDR_W-1:0] baseAddr;
  logic [bridge_cfg_pkg::HOST_ADDR_W-1:0] limitAddr;

  // Base aligned down, limit filled up to the top of its megabyte
  assign baseAddr  = {baseHigh, baseLow, bridge_cfg_pkg::BASE_LOW_FILL};
  assign limitAddr = {limitHigh, limitLow, bridge_cfg_pkg::LIMIT_LOW_FILL};

  // Inclusive at both ends
  assign inWindow = (addr >= baseAddr) && (addr <= limitAddr);

endmodule
